// ==== pkg/mscr_map.vh ====
/*
  register map constants for the metering system configuration register.
  assumes inclusion by bare name from the design file.
*/
`ifndef MSCR_MAP_VH
`define MSCR_MAP_VH

// ----------------------------------------
// addresses
// ----------------------------------------
`define MSCR_CFG_ADDR     12'h000
`define MSCR_ADDR_W       12

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSCR_CH1_HI       29
`define MSCR_CH1_LO       27
`define MSCR_CH0_HI       26
`define MSCR_CH0_LO       24
`define MSCR_TC_HI        23
`define MSCR_TC_LO        16
`define MSCR_SW_BIT       8

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define MSCR_GAIN_RST     3'h0
`define MSCR_TC_RST       8'h00
`define MSCR_SW_RST       1'b0
`define MSCR_CODE_G16     3'h4
`define MSCR_CODE_G32     3'h5
`define MSCR_CODE_RES0    3'h6
`define MSCR_CODE_RES1    3'h7
`define MSCR_ZERO32       32'h00000000
`define MSCR_CODE_G1      3'h0
`define MSCR_CODE_G2      3'h1
`define MSCR_CODE_G4      3'h2
`define MSCR_CODE_G8      3'h3

// ----------------------------------------
// one-hot gain selects and constant fields
// ----------------------------------------
`define MSCR_SEL_G1       6'h01
`define MSCR_SEL_G2       6'h02
`define MSCR_SEL_G4       6'h04
`define MSCR_SEL_G8       6'h08
`define MSCR_SEL_G16      6'h10
`define MSCR_SEL_G32      6'h20
`define MSCR_PAD_TOP      2'h0
`define MSCR_GAP_BITS     7'h00
`define MSCR_PAD_LOW      8'h00
`define MSCR_ERR_NONE     1'h0

`endif

// ==== verilog/mscr_config_reg.v ====
/*
  system configuration register of a power-monitoring front end, as an apb slave,
  with decoded channel gain selects and the single-wire enable as outputs.
  assumes a single pclk domain and an apb master keeping the apb protocol.
*/
// Notes on behaviour
// RL1: channel one gain code is held in bits 29 to 27.
// RL2: channel zero gain code is held in bits 26 to 24.
// RL3: code 101 selects gain 32 and code 100 selects gain 16 on either channel.
// RL4: both gain codes reset to 000, which selects unity gain.
// RL5: reserved codes 111 and 110 act as unity gain.
// RL6: bits 23 to 16 hold the reference temperature-coefficient value.
// RL7: bits 15 to 9 are unimplemented and read as zero.
// RL8: bit 8 enables single-wire transmission when 1, and resets to 0.
// RL9: every implemented field reads back what was last written until rewritten or reset.
`timescale 1ns/1ps
`include "mscr_map.vh"

module mscr_config_reg (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [5:0]  channel1_gain_log2,
  output reg  [5:0]  channel0_gain_log2,
  output reg  [7:0]  reference_tempco_value,
  output reg         single_wire_enable
);

  // ----------------------------------------
  // local state encodings
  // ----------------------------------------
  // one-hot bus phase: access means the previous edge saw a setup cycle
  localparam [1:0] PH_IDLE       = 2'h1;
  localparam [1:0] PH_ACCESS     = 2'h2;
  localparam       PH_ACCESS_BIT = 1;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // one-hot gain: bit n set means gain of 2**n; unknown codes fall to unity
  function [5:0] mscr_gain;
    input [2:0] code;
    begin
      case (code)
        `MSCR_CODE_G32:  mscr_gain = `MSCR_SEL_G32; // [RL3]
        `MSCR_CODE_G16:  mscr_gain = `MSCR_SEL_G16; // [RL3]
        `MSCR_CODE_G8:   mscr_gain = `MSCR_SEL_G8;
        `MSCR_CODE_G4:   mscr_gain = `MSCR_SEL_G4;
        `MSCR_CODE_G2:   mscr_gain = `MSCR_SEL_G2;
        `MSCR_CODE_G1:   mscr_gain = `MSCR_SEL_G1;  // [RL4]
        `MSCR_CODE_RES0: mscr_gain = `MSCR_SEL_G1;  // [RL5]
        `MSCR_CODE_RES1: mscr_gain = `MSCR_SEL_G1;  // [RL5]
        default:         mscr_gain = `MSCR_SEL_G1;
      endcase
    end
  endfunction

  // only the low address bits are decoded, so the word aliases higher up
  function mscr_hit;
    input [31:0] addr;
    begin
      mscr_hit = (addr[`MSCR_ADDR_W-1:0] == `MSCR_CFG_ADDR);
    end
  endfunction

  // read word assembly; unimplemented and unmodelled bits are constant zero
  function [31:0] mscr_pack;
    input [2:0] ch1;
    input [2:0] ch0;
    input [7:0] tc;
    input       sw;
    begin
      mscr_pack = {`MSCR_PAD_TOP,
                   ch1,            // [RL1]
                   ch0,            // [RL2]
                   tc,             // [RL6]
                   `MSCR_GAP_BITS, // [RL7]
                   sw,             // [RL8]
                   `MSCR_PAD_LOW};
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [1:0]  phase_q;
  reg  [1:0]  phase_d;
  reg         pslverr_q;
  reg  [2:0]  channel1_gain_code_q;
  reg  [2:0]  channel0_gain_code_q;
  wire        setup_cyc;
  wire        access_cyc;
  wire        hit;
  wire        wr_en;
  wire        rd_en;
  wire [31:0] rd_word;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign setup_cyc  = psel & ~penable;
  assign access_cyc = psel & penable;
  assign hit        = mscr_hit(paddr);
  assign wr_en      = access_cyc & pwrite & hit;
  assign rd_en      = setup_cyc & ~pwrite;
  assign rd_word    = mscr_pack(channel1_gain_code_q, channel0_gain_code_q,
                                reference_tempco_value, single_wire_enable);

  // ----------------------------------------
  // bus phase
  // ----------------------------------------
  // ready comes from a flop set by the setup edge, so no wait state is added
  always @* begin
    phase_d = PH_IDLE;
    case (phase_q)
      PH_IDLE: begin
        if (setup_cyc) begin
          phase_d = PH_ACCESS;
        end
      end
      PH_ACCESS: begin
        // ready is already high, so every access lasts exactly one cycle
        phase_d = PH_IDLE;
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= PH_IDLE;
      pslverr_q <= `MSCR_ERR_NONE;
    end else begin
      phase_q   <= phase_d;
      // every word is writable or reads as zero, so no transfer is refused
      pslverr_q <= `MSCR_ERR_NONE;
    end
  end

  // ----------------------------------------
  // handshake outputs
  // ----------------------------------------
  assign pready  = phase_q[PH_ACCESS_BIT];
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // field registers
  // ----------------------------------------
  // each field holds its value between writes [RL9]
  // reserved codes are kept as written; only the decode treats them as unity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel1_gain_code_q <= `MSCR_GAIN_RST; // [RL4]
    end else if (wr_en) begin
      channel1_gain_code_q <= pwdata[`MSCR_CH1_HI:`MSCR_CH1_LO]; // [RL1]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_gain_code_q <= `MSCR_GAIN_RST; // [RL4]
    end else if (wr_en) begin
      channel0_gain_code_q <= pwdata[`MSCR_CH0_HI:`MSCR_CH0_LO]; // [RL2]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_tempco_value <= `MSCR_TC_RST;
    end else if (wr_en) begin
      reference_tempco_value <= pwdata[`MSCR_TC_HI:`MSCR_TC_LO]; // [RL6]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_wire_enable <= `MSCR_SW_RST; // [RL8]
    end else if (wr_en) begin
      single_wire_enable <= pwdata[`MSCR_SW_BIT]; // [RL8]
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // read data is registered in the setup cycle so prdata is a flop output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `MSCR_ZERO32;
    end else if (rd_en) begin
      prdata <= hit ? rd_word : `MSCR_ZERO32; // [RL9]
    end
  end

  // ----------------------------------------
  // decoded gains
  // ----------------------------------------
  // gain outputs lag the code by one cycle so they come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel1_gain_log2 <= `MSCR_SEL_G1; // [RL4]
    end else begin
      channel1_gain_log2 <= mscr_gain(channel1_gain_code_q); // [RL3][RL5]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_gain_log2 <= `MSCR_SEL_G1; // [RL4]
    end else begin
      channel0_gain_log2 <= mscr_gain(channel0_gain_code_q); // [RL3][RL5]
    end
  end

endmodule // mscr_config_reg

// ==== verification/mscr_props.sv ====
/* port checker for mscr_config_reg; assumes one pclk domain, bound at the foot */
`timescale 1ns/1ps
module mscr_props (input logic pclk, presetn, psel, penable, pwrite, pready, pslverr, single_wire_enable,
  input logic [31:0] paddr, pwdata, prdata, input logic [5:0] channel1_gain_log2, channel0_gain_log2,
  input logic [7:0] reference_tempco_value);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pwrite & paddr[11:0] == 12'h000;
  chk_g1_top: assert property (wr && pwdata[29:27]==3'h5 |=> ##1 channel1_gain_log2==6'h20)
    else $error("gain1");
  chk_g0_mid: assert property (wr && pwdata[26:24]==3'h4 |=> ##1 channel0_gain_log2==6'h10)
    else $error("gain0");
  chk_rsvd_unity: assert property (wr && pwdata[29:28]==2'h3 |=> ##1 channel1_gain_log2==6'h01)
    else $error("unity");
  chk_tc_load: assert property (wr |=> reference_tempco_value==$past(pwdata[23:16]))
    else $error("tempco");
  chk_sw_load: assert property (wr |=> single_wire_enable==$past(pwdata[8]))
    else $error("enable");
  chk_gap_zero: assert property (prdata[15:9]==7'h00)
    else $error("gap");
  chk_rst_unity: assert property ($rose(presetn) |-> channel0_gain_log2==6'h01 && !single_wire_enable)
    else $error("reset");
  chk_tc_hold: assert property (!wr |=> $stable(reference_tempco_value))
    else $error("hold");
  chk_ack_noerr: assert property (psel && !penable |=> pready && !pslverr)
    else $error("handshake");
  cover property (wr);
  cover property (wr && pwdata[29:28]==2'h3);
  cover property ($rose(presetn));
endmodule // mscr_props
bind mscr_config_reg mscr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .single_wire_enable(single_wire_enable),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .channel1_gain_log2(channel1_gain_log2),
  .channel0_gain_log2(channel0_gain_log2), .reference_tempco_value(reference_tempco_value));

// ==== verification/tb_mscr_config_reg.sv ====
/* apb bench for mscr_config_reg; assumes mscr_props binds itself */
`timescale 1ns/1ps
module tb_mscr_config_reg;
  logic        pclk=0, presetn=0, psel=0, penable=0, pwrite=0;
  logic [31:0] paddr=0, pwdata=0, d, q[$];
  wire  [31:0] prdata;
  wire         pready, pslverr, single_wire_enable;
  wire  [5:0]  channel1_gain_log2, channel0_gain_log2;
  wire  [7:0]  reference_tempco_value;
  integer      error_cnt=0, compares=0, seed=32'hB1ABCD58;
  mscr_config_reg uut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .channel1_gain_log2     (channel1_gain_log2),
    .channel0_gain_log2     (channel0_gain_log2),
    .reference_tempco_value (reference_tempco_value),
    .single_wire_enable     (single_wire_enable)
  );
  always #20 pclk = ~pclk;
  function automatic [5:0] oh(input [2:0] c);
    return c>5 ? 6'h01 : 6'h01<<c;
  endfunction
  task automatic chk(input [31:0] s, e);
    compares++;
    if (s!==e) begin error_cnt++; $display("mismatch %0t %h %h", $time, s, e); end
  endtask
  task apb(input w, input [31:0] a, v);
    psel<=1; pwrite<=w; paddr<=a; pwdata<=v;
    @(posedge pclk) penable<=1;
    do @(posedge pclk); while (pready!==1);
    psel<=0; penable<=0;
    @(posedge pclk);
  endtask
  task rd(input [31:0] a, e);
    q.push_back(e);
    apb(0, a, $random(seed));
  endtask
  always @(posedge pclk) if (psel && penable && !pwrite && pready) chk(prdata, q.pop_front());
  task give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt==0 && compares>0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin #20000 error_cnt++; give_verdict; end
  initial begin
    repeat (2) @(posedge pclk);
    presetn<=1;
    @(posedge pclk) rd(0, 0);
    for (int i=0; i<8; i++) begin
      d = $random(seed);
      d[29:24] = {i[2:0], ~i[2:0]};
      apb(1, 0, d);
      #1 chk({channel1_gain_log2, channel0_gain_log2, reference_tempco_value, single_wire_enable},
        {oh(d[29:27]), oh(d[26:24]), d[23:16], d[8]});
      @(posedge pclk) apb(1, 4, ~d);
      rd(4, 0);
      rd(0, d & 32'h3FFF0100);
    end
    presetn<=0;
    @(posedge pclk) presetn<=1;
    @(posedge pclk) rd(0, 0);
    give_verdict;
  end
endmodule // tb_mscr_config_reg
